// >>> rtl/vcpa_arb_table.sv
// virtual channel status, port arbitration table registers, table load and egress arbiter
`timescale 1ns/1ps
`include "vcpa_consts.svh"

module vcpa_arb_table
    import vcpa_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        sys_rst,
    input  wire logic        clk_en,
    input  wire logic [11:0] reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_write,
    input  wire logic        reg_read,
    output logic [31:0]      reg_rdata,
    input  wire logic        is_upstream_port,
    input  wire logic        arb_table_in_use,
    input  wire logic [1:0]  egress_port_id,
    input  wire logic        link_dl_active,
    input  wire logic        link_in_fc_init1,
    input  wire logic        link_in_fc_init2,
    input  wire logic        arb_period_done,
    output logic [1:0]       offer_port,
    output logic             offer_valid,
    output logic [3:0]       offer_phase,
    output logic             load_busy,
    output logic             irq
);

    vcpa_table_type      table_live;
    vcpa_table_type      table_latched;
    vcpa_load_state_type load_state;
    logic [3:0]          copy_idx;
    logic                arb_table_dirty;
    logic                rewritten;
    logic                channel_negotiation_pending;
    logic                fc_init2_q;
    logic [`VCPA_IRQ_WIDTH-1:0] irq_status;
    logic [`VCPA_IRQ_WIDTH-1:0] irq_mask;
    logic [`VCPA_IRQ_WIDTH-1:0] next_irq_status;
    logic [`VCPA_IRQ_WIDTH-1:0] next_irq_mask;
    logic [`VCPA_IRQ_WIDTH-1:0] irq_events;
    logic                write_a;
    logic                write_b;
    logic                table_write;
    logic                load_table_request;
    logic                copy_last;
    logic                neg_done;
    logic                channel_enable_flag;
    logic [31:0]         next_rdata;

    function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
        hit = (a == off);
    endfunction

    // ------------------------------------------------------------ decode
    always_comb begin
        write_a             = reg_write && hit(reg_addr, `VCPA_OFF_WORD_A);
        write_b             = reg_write && hit(reg_addr, `VCPA_OFF_WORD_B);
        table_write         = write_a || write_b;
        // a request while a load runs is dropped; the running copy already owns the table
        // a load is refused while the selected scheme ignores the table, dirty means nothing then
        load_table_request  = reg_write && hit(reg_addr, `VCPA_OFF_CONTROL)
                              && reg_wdata[`VCPA_LOAD_BIT] && is_upstream_port
                              && arb_table_in_use && (load_state == LOAD_IDLE);
        copy_last           = (load_state == LOAD_COPY) && (copy_idx == `VCPA_LAST_SLOT);
        neg_done            = fc_init2_q && !link_in_fc_init2;
        channel_enable_flag = 1'b1;
    end

    // ------------------------------------------------------------ live table
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            table_live <= `VCPA_TABLE_RESET;
        end else if (clk_en) begin
            if (write_a) begin
                table_live[`VCPA_SLOTS_A-1:0] <= reg_wdata;
            end
            if (write_b) begin
                // slots above 11 are not implemented, upper half of the word is dropped
                table_live[`VCPA_SLOT_COUNT-1:`VCPA_SLOTS_A] <= reg_wdata[15:0];
            end
        end
    end

    // ------------------------------------------------------------ load sequence
    // one slot per cycle keeps the copy a plain 4-bit mux at the cost of twelve cycles
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            load_state <= LOAD_IDLE;
            copy_idx   <= 4'h0;
        end else if (clk_en) begin
            case (load_state)
                LOAD_IDLE: begin
                    copy_idx <= 4'h0;
                    if (load_table_request) begin
                        load_state <= LOAD_COPY;
                    end
                end
                LOAD_COPY: begin
                    if (copy_last) begin
                        load_state <= LOAD_IDLE;
                        copy_idx   <= 4'h0;
                    end else begin
                        copy_idx <= copy_idx + 4'h1;
                    end
                end
                default: begin
                    load_state <= LOAD_IDLE;
                    copy_idx   <= 4'h0;
                end
            endcase
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            table_latched <= `VCPA_TABLE_RESET;
        end else if (clk_en) begin
            if (load_state == LOAD_COPY) begin
                table_latched[copy_idx] <= table_live[copy_idx];
            end
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            load_busy <= 1'b0;
        end else if (clk_en) begin
            load_busy <= load_table_request || ((load_state == LOAD_COPY) && !copy_last);
        end
    end

    // ------------------------------------------------------------ table dirty
    // a write that lands during the copy may miss slots already taken, so dirty must survive
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            rewritten <= 1'b0;
        end else if (clk_en) begin
            if (load_table_request) begin
                rewritten <= 1'b0;
            end else if (table_write && (load_state == LOAD_COPY)) begin
                rewritten <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            arb_table_dirty <= 1'b0;
        end else if (clk_en) begin
            if (table_write && is_upstream_port) begin
                arb_table_dirty <= 1'b1;
            end else if (copy_last && !rewritten) begin
                arb_table_dirty <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------ negotiation pending
    // the stored bit keeps tracking while the link is down; only the read is gated
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            fc_init2_q <= 1'b0;
        end else if (clk_en) begin
            fc_init2_q <= link_in_fc_init2;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            channel_negotiation_pending <= 1'b0;
        end else if (clk_en) begin
            if (link_in_fc_init1 || link_in_fc_init2) begin
                channel_negotiation_pending <= 1'b1;
            end else if (neg_done) begin
                channel_negotiation_pending <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------ interrupts
    always_comb begin
        irq_events                      = '0;
        irq_events[`VCPA_IRQ_LOADED]    = copy_last;
        irq_events[`VCPA_IRQ_NEG_DONE]  = neg_done;
        irq_events[`VCPA_IRQ_WRITTEN]   = table_write && is_upstream_port;
        next_irq_status                 = irq_status;
        if (reg_read && hit(reg_addr, `VCPA_OFF_IRQ_STATUS)) begin
            next_irq_status = '0;
        end
        // an event in the clearing cycle is kept
        next_irq_status = next_irq_status | irq_events;
    end

    always_comb begin
        next_irq_mask = irq_mask;
        if (reg_write && hit(reg_addr, `VCPA_OFF_IRQ_MASK)) begin
            next_irq_mask = reg_wdata[`VCPA_IRQ_WIDTH-1:0];
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            irq_status <= '0;
        end else if (clk_en) begin
            irq_status <= next_irq_status;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            irq_mask <= '0;
        end else if (clk_en) begin
            irq_mask <= next_irq_mask;
        end
    end

    // built from the next values so the line moves in the same edge as the status bit
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            irq <= 1'b0;
        end else if (clk_en) begin
            irq <= |(next_irq_status & next_irq_mask);
        end
    end

    // ------------------------------------------------------------ read data
    always_comb begin
        next_rdata = 32'h0000_0000;
        case (reg_addr)
            `VCPA_OFF_CONTROL: begin
                // load request always reads zero
                next_rdata[`VCPA_ENABLE_BIT] = channel_enable_flag;
            end
            `VCPA_OFF_STATUS: begin
                // not masked by arb_table_in_use: the bit is simply meaningless then
                next_rdata[`VCPA_DIRTY_BIT] = arb_table_dirty && is_upstream_port;
                next_rdata[`VCPA_NEG_BIT]   = channel_negotiation_pending
                                              && link_dl_active && channel_enable_flag;
            end
            `VCPA_OFF_WORD_A: begin
                next_rdata = table_live[`VCPA_SLOTS_A-1:0];
            end
            `VCPA_OFF_WORD_B: begin
                next_rdata[15:0] = table_live[`VCPA_SLOT_COUNT-1:`VCPA_SLOTS_A];
            end
            `VCPA_OFF_IRQ_STATUS: begin
                // shows the bits from before this same read clears them
                next_rdata[`VCPA_IRQ_WIDTH-1:0] = irq_status;
            end
            `VCPA_OFF_IRQ_MASK: begin
                next_rdata[`VCPA_IRQ_WIDTH-1:0] = irq_mask;
            end
            default: begin
                next_rdata = 32'h0000_0000;
            end
        endcase
    end

    // writes to the status word have no decode and are ignored
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            reg_rdata <= 32'h0000_0000;
        end else if (clk_en) begin
            reg_rdata <= reg_read ? next_rdata : 32'h0000_0000;
        end
    end

    // ------------------------------------------------------------ arbiter
    // walker trusts software to keep reserved codes out, but still skips them safely
    // during a load the walker may briefly see a mix of old and new slots
    vcpa_slot_walker u_walker (
        .clk             (clk),
        .sys_rst         (sys_rst),
        .clk_en          (clk_en),
        .table_latched   (table_latched),
        .egress_port_id  (egress_port_id),
        .arb_period_done (arb_period_done),
        .offer_port      (offer_port),
        .offer_valid     (offer_valid),
        .offer_phase     (offer_phase)
    );

endmodule

// >>> rtl/vcpa_consts.svh
// offsets, field positions, reset values and counts of the arbitration table block
`ifndef VCPA_CONSTS_SVH
`define VCPA_CONSTS_SVH

// register byte offsets
`define VCPA_OFF_CONTROL    12'h214
`define VCPA_OFF_STATUS     12'h218
`define VCPA_OFF_WORD_A     12'h220
`define VCPA_OFF_WORD_B     12'h224
`define VCPA_OFF_IRQ_STATUS 12'h230
`define VCPA_OFF_IRQ_MASK   12'h234

// field positions
`define VCPA_LOAD_BIT       16
`define VCPA_ENABLE_BIT     31
`define VCPA_DIRTY_BIT      16
`define VCPA_NEG_BIT        17

// interrupt status bits
`define VCPA_IRQ_LOADED     0
`define VCPA_IRQ_NEG_DONE   1
`define VCPA_IRQ_WRITTEN    2
`define VCPA_IRQ_WIDTH      3

// table geometry and codes
`define VCPA_SLOT_COUNT     12
`define VCPA_LAST_SLOT      4'hb
`define VCPA_MAX_PORT       4'h3
`define VCPA_SLOTS_A        8
`define VCPA_TABLE_RESET    48'h5432_1765_4321

`endif

// >>> rtl/vcpa_pkg.sv
// types shared by the arbitration table block
package vcpa_pkg;
    typedef logic [3:0]        vcpa_slot_type;
    typedef logic [11:0][3:0]  vcpa_table_type;
    typedef enum logic [0:0] {
        LOAD_IDLE,
        LOAD_COPY
    } vcpa_load_state_type;
endpackage

// >>> rtl/vcpa_slot_walker.sv
// phase walker that offers each arbitration period to the port named in the current slot
`timescale 1ns/1ps
`include "vcpa_consts.svh"

module vcpa_slot_walker
    import vcpa_pkg::*;
(
    input  wire logic           clk,
    input  wire logic           sys_rst,
    input  wire logic           clk_en,
    input  wire vcpa_table_type table_latched,
    input  wire logic [1:0]     egress_port_id,
    input  wire logic           arb_period_done,
    output logic [1:0]          offer_port,
    output logic                offer_valid,
    output logic [3:0]          offer_phase
);

    logic [3:0] phase;
    logic [3:0] start_phase;
    logic [3:0] next_phase;

    // reserved codes and the egress port itself are never offered
    function automatic logic slot_ok(input vcpa_slot_type code, input logic [1:0] egr);
        slot_ok = (code <= `VCPA_MAX_PORT) && (code[1:0] != egr);
    endfunction

    function automatic logic [3:0] next_index(input logic [3:0] i);
        next_index = (i == `VCPA_LAST_SLOT) ? 4'h0 : i + 4'h1;
    endfunction

    // skipping is done within one cycle so an invalid slot costs no period
    function automatic logic [3:0] first_valid(input vcpa_table_type t, input logic [3:0] from,
                                               input logic [1:0] egr);
        logic [3:0] idx;
        logic       found;
        begin
            idx         = from;
            found       = 1'b0;
            first_valid = from;
            for (int k = 0; k < `VCPA_SLOT_COUNT; k++) begin
                if (!found && slot_ok(t[idx], egr)) begin
                    found       = 1'b1;
                    first_valid = idx;
                end
                idx = next_index(idx);
            end
        end
    endfunction

    always_comb begin
        start_phase = (arb_period_done && offer_valid) ? next_index(phase) : phase;
        next_phase  = first_valid(table_latched, start_phase, egress_port_id);
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            phase       <= 4'h0;
            offer_phase <= 4'h0;
            offer_port  <= 2'h0;
            offer_valid <= 1'b0;
        end else if (clk_en) begin
            phase       <= next_phase;
            offer_phase <= next_phase;
            offer_port  <= table_latched[next_phase][1:0];
            offer_valid <= slot_ok(table_latched[next_phase], egress_port_id);
        end
    end

endmodule

// >>> sim/vcpa_arb_table_monitor.sv
// concurrent checks on the ports of the arbitration table block
`timescale 1ns/1ps
module vcpa_arb_table_monitor (
    input wire logic        clk,
    input wire logic        sys_rst,
    input wire logic        clk_en,
    input wire logic [11:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic        reg_write,
    input wire logic        reg_read,
    input wire logic [31:0] reg_rdata,
    input wire logic        is_upstream_port,
    input wire logic        arb_table_in_use,
    input wire logic [1:0]  egress_port_id,
    input wire logic        link_dl_active,
    input wire logic        arb_period_done,
    input wire logic [3:0]  offer_phase,
    input wire logic        load_busy
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);
    logic rd_sts;
    logic ld_req;
    assign rd_sts = clk_en && reg_read && reg_addr == 12'h218;
    assign ld_req = clk_en && reg_write && reg_addr == 12'h214 && reg_wdata[16];

    a_status_rsvd_zero: assert property (rd_sts |=> reg_rdata[15:0] == 16'h0 && reg_rdata[31:18] == 14'h0)
        else $error("status reserved bits not zero");
    a_dirty_down_zero: assert property (rd_sts && !is_upstream_port |=> !reg_rdata[16])
        else $error("dirty bit set on downstream port");
    a_neg_inactive_zero: assert property (rd_sts && !link_dl_active |=> !reg_rdata[17])
        else $error("pending bit set outside active link");
    a_load_busy_len: assert property (ld_req && is_upstream_port && arb_table_in_use && !load_busy
        |=> load_busy [*8] ##1 load_busy [*4] ##1 !load_busy)
        else $error("table load length wrong");
    a_load_refused: assert property (ld_req && (!is_upstream_port || !arb_table_in_use) && !load_busy
        |=> !load_busy)
        else $error("refused load started");
    a_ctl_read_value: assert property (clk_en && reg_read && reg_addr == 12'h214 |=> reg_rdata == 32'h8000_0000)
        else $error("control read wrong");
    a_word_b_upper: assert property (clk_en && reg_read && reg_addr == 12'h224 |=> reg_rdata[31:16] == 16'h0)
        else $error("word b upper half not zero");
    a_phase_in_range: assert property (offer_phase <= 4'hb)
        else $error("offered phase out of range");
    // loads and egress changes may move the offer one edge late, so both are kept out of the window
    a_offer_held: assert property (clk_en && !arb_period_done && !load_busy && !$past(load_busy)
        && !$past(sys_rst) && $past(egress_port_id, 2) == egress_port_id && $stable(egress_port_id)
        |=> $stable(offer_phase))
        else $error("offer moved without a period pulse");
endmodule

bind vcpa_arb_table vcpa_arb_table_monitor mon_u (.clk(clk), .sys_rst(sys_rst), .clk_en(clk_en),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .is_upstream_port(is_upstream_port), .arb_table_in_use(arb_table_in_use),
    .egress_port_id(egress_port_id), .link_dl_active(link_dl_active), .arb_period_done(arb_period_done),
    .offer_phase(offer_phase), .load_busy(load_busy));

// >>> sim/vcpa_arb_table_tb.sv
// self-checking bench for the arbitration table block
`timescale 1ns/1ps
module vcpa_arb_table_tb;
    logic        clk = 1'b0;
    logic        sys_rst = 1'b1;
    logic        clk_en = 1'b1;
    logic [11:0] reg_addr = 12'h0;
    logic [31:0] reg_wdata = 32'h0;
    logic        reg_write = 1'b0;
    logic        reg_read = 1'b0;
    logic [31:0] reg_rdata;
    logic        is_upstream_port = 1'b1;
    logic        arb_table_in_use = 1'b1;
    logic [1:0]  egress_port_id = 2'h0;
    logic        link_dl_active = 1'b0;
    logic        link_in_fc_init1 = 1'b0;
    logic        link_in_fc_init2 = 1'b0;
    logic        arb_period_done = 1'b0;
    logic [1:0]  offer_port;
    logic        offer_valid;
    logic [3:0]  offer_phase;
    logic        load_busy;
    logic        irq;
    logic [3:0]  tbl [12];
    logic [3:0]  exp_ph = 4'h0;
    int          n_mismatch = 0;
    int          n_checks = 0;

    always #5 clk = ~clk;

    vcpa_arb_table dut_u (.clk(clk), .sys_rst(sys_rst), .clk_en(clk_en), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
        .is_upstream_port(is_upstream_port), .arb_table_in_use(arb_table_in_use),
        .egress_port_id(egress_port_id), .link_dl_active(link_dl_active),
        .link_in_fc_init1(link_in_fc_init1), .link_in_fc_init2(link_in_fc_init2),
        .arb_period_done(arb_period_done), .offer_port(offer_port), .offer_valid(offer_valid),
        .offer_phase(offer_phase), .load_busy(load_busy), .irq(irq));

    task automatic close_out();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] v);
        @(posedge clk);
        reg_write <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= v;
        @(posedge clk);
        reg_write <= 1'b0;
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] exp, input string nm);
        @(posedge clk);
        reg_read <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_read <= 1'b0;
        #1 chk(nm, exp, reg_rdata);
    endtask

    // first slot at or after p that names a usable port; codes above 3 and the own port do not count
    function automatic logic [3:0] nxt(input logic [3:0] p);
        logic [3:0] s;
        s = p;
        for (int k = 0; k < 12; k++) begin
            if (tbl[s] <= 4'h3 && tbl[s][1:0] != egress_port_id)
                return s;
            s = (s == 4'hb) ? 4'h0 : s + 4'h1;
        end
        return p;
    endfunction

    task automatic walk(input int n);
        for (int k = 0; k < n; k++) begin
            chk("offer_phase", {28'h0, exp_ph}, {28'h0, offer_phase});
            chk("offer_port", {28'h0, tbl[exp_ph]}, {28'h0, 2'b00, offer_port});
            chk("offer_valid", 32'h1, {31'h0, offer_valid});
            @(posedge clk);
            arb_period_done <= 1'b1;
            @(posedge clk);
            arb_period_done <= 1'b0;
            #1 exp_ph = nxt((exp_ph == 4'hb) ? 4'h0 : exp_ph + 4'h1);
        end
    endtask

    task automatic load(input int exp_n);
        int n;
        n = 0;
        wr(12'h214, 32'h0001_0000);
        #1;
        while (load_busy === 1'b1 && n < 40) begin
            n++;
            @(posedge clk);
            #1;
        end
        chk("load cycles", exp_n, n);
        if (n == 40)
            close_out();
    endtask

    initial begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        $display("[ERR] run length expected end seen none");
        close_out();
    end

    initial begin
        tbl = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5};
        repeat (6) @(posedge clk);
        sys_rst <= 1'b0;
        rd(12'h220, 32'h1765_4321, "word a reset");
        rd(12'h224, 32'h0000_5432, "word b reset");
        rd(12'h218, 32'h0, "status reset");
        rd(12'h214, 32'h8000_0000, "control");
        rd(12'h3fc, 32'h0, "unmapped");
        rd(12'h234, 32'h0, "irq mask reset");
        // stop on phase 1, whose code stays valid while the later load copies slot by slot
        walk(13);
        $display("test reset and walk done");
        wr(12'h220, 32'h1111_2f30);
        wr(12'h224, 32'hffff_0003);
        wr(12'h218, 32'hffff_ffff);
        rd(12'h220, 32'h1111_2f30, "word a");
        rd(12'h224, 32'h0000_0003, "word b");
        rd(12'h218, 32'h0001_0000, "status dirty");
        chk("irq masked", 32'h0, {31'h0, irq});
        wr(12'h234, 32'h4);
        @(posedge clk);
        #1 chk("irq raised", 32'h1, {31'h0, irq});
        rd(12'h230, 32'h4, "irq status");
        chk("irq cleared", 32'h0, {31'h0, irq});
        $display("test table write done");
        load(12);
        rd(12'h218, 32'h0, "status after load");
        rd(12'h230, 32'h1, "irq load done");
        tbl = '{4'h0, 4'h3, 4'hf, 4'h2, 4'h1, 4'h1, 4'h1, 4'h1, 4'h3, 4'h0, 4'h0, 4'h0};
        exp_ph = nxt(exp_ph);
        walk(10);
        @(posedge clk);
        egress_port_id <= 2'h1;
        repeat (3) @(posedge clk);
        exp_ph = nxt(exp_ph);
        walk(6);
        @(posedge clk);
        clk_en <= 1'b0;
        arb_period_done <= 1'b1;
        @(posedge clk);
        arb_period_done <= 1'b0;
        @(posedge clk);
        clk_en <= 1'b1;
        #1 chk("offer frozen", {28'h0, exp_ph}, {28'h0, offer_phase});
        $display("test load and walk done");
        @(posedge clk);
        is_upstream_port <= 1'b0;
        wr(12'h220, 32'h0);
        rd(12'h218, 32'h0, "status downstream");
        load(0);
        @(posedge clk);
        is_upstream_port <= 1'b1;
        arb_table_in_use <= 1'b0;
        wr(12'h224, 32'h1);
        load(0);
        rd(12'h218, 32'h0001_0000, "dirty held");
        $display("test refused loads done");
        @(posedge clk);
        arb_table_in_use <= 1'b1;
        link_dl_active <= 1'b1;
        link_in_fc_init1 <= 1'b1;
        rd(12'h218, 32'h0003_0000, "neg pending");
        @(posedge clk);
        link_in_fc_init1 <= 1'b0;
        link_in_fc_init2 <= 1'b1;
        link_dl_active <= 1'b0;
        rd(12'h218, 32'h0001_0000, "neg outside active");
        @(posedge clk);
        link_dl_active <= 1'b1;
        link_in_fc_init2 <= 1'b0;
        rd(12'h218, 32'h0001_0000, "neg cleared");
        rd(12'h230, 32'h6, "irq neg and write");
        $display("test negotiation done");
        wr(12'h214, 32'h0001_0000);
        wr(12'h224, 32'h0000_3333);
        repeat (14) @(posedge clk);
        rd(12'h218, 32'h0001_0000, "dirty after write during load");
        load(12);
        rd(12'h218, 32'h0, "dirty after clean load");
        $display("test write during load done");
        @(posedge clk);
        sys_rst <= 1'b1;
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        rd(12'h220, 32'h1765_4321, "word a second reset");
        chk("offer after reset", 32'h1, {28'h0, offer_phase});
        $display("test second reset done");
        close_out();
    end
endmodule
